// File: rtl/rsd_defs.svh
// constants of the rtc supervision and power-on defaults block
// What this block does
// - battery check at every power-up and every 24 hours while mains present
// - failed battery check sets battery-low flag, flags register bit 4
// - battery-low flag holds until a later check passes
// - no battery checks while running from backup supply
// - two century bits count up in binary at century rollover
// - leap every fourth year; century years leap only when century bits are zero
// - with no interrupt source enabled the pin follows the output-level bit
// - interrupt pin is open drain: pulls low or releases only
// - oscillator-fail flag sets whenever the oscillator stops, for any cause
// - oscillator-fail flag is caught even when the stop occurs during power-down
// - oscillator-fail flag holds until software writes zero while the oscillator runs and is not halted
// - fail enable and fail flag pull the pin low; flag read does not release
// - first power-up clears listed control bits, sets pin level and square-wave enable
// - first power-up clears timer and alarm bits, sets stamp, fail flag, selects
// - later power-up clears test and countdown run; sets power-loss stamp
// - unlisted control bits have no guaranteed power-on value
// - trim-load set copies factory trim into analog trim register, read-only
// - trim-load clear makes analog trim an ordinary read-write register
`ifndef RSD_DEFS_SVH
`define RSD_DEFS_SVH
// ==========================================
// timing
`define RSD_CLK_NS          100'd10
`define RSD_OSC_HZ          32768
`define RSD_CHECK_HOURS     24
`define RSD_CHECK_TICKS     (64'd1 * `RSD_CHECK_HOURS * 3600 * `RSD_OSC_HZ)
`define RSD_TRIM_LOAD_MS    8
`define RSD_TRIM_LOAD_TICKS ((`RSD_TRIM_LOAD_MS * `RSD_OSC_HZ + 999) / 1000)
// ==========================================
// field positions
`define RSD_FLAGS_BATLOW_BIT 4
`define RSD_CTRL_OUT_BIT     7
// ==========================================
// first power-up reset values
`define RSD_INIT_OUT         1'b1
`define RSD_INIT_SQUARE_WAVE_ON        1'b1
`define RSD_INIT_CLKSEL      2'h3
`define RSD_INIT_RATE0       1'b1
`define RSD_INIT_STAMP       1'b1
`define RSD_INIT_OSCFAIL     1'b1
`endif

// File: rtl/rsd_pkg.sv
// types of the rtc supervision block
package rsd_pkg;
	typedef enum logic [1:0] {
		RSD_PWR_OFF,
		RSD_PWR_FIRST,
		RSD_PWR_LATER,
		RSD_PWR_ON
	} rsd_pwr_e;
endpackage

// File: rtl/rsd_supervisor.sv
// supervision: battery check, century, interrupt pin, oscillator fail, defaults
`timescale 1ns/1ps
`include "rsd_defs.svh"
module rsd_supervisor #(
	parameter logic [31:0] CHECK_TICKS = 32'(`RSD_CHECK_TICKS)
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       oscTick,
	input  wire logic       mainsGood,
	input  wire logic       firstPowerUp,
	input  wire logic       batteryOk,
	input  wire logic       oscRunning,
	input  wire logic       yearRollover,
	input  wire logic [7:0] yearUnits,
	input  wire logic       ctrlWrite,
	input  wire logic [7:0] ctrlWrData,
	input  wire logic       oscFailClear,
	input  wire logic       watchdogIrqOn,
	input  wire logic       alarm1Irq,
	input  wire logic       watchdogIrq,
	input  wire logic       trimWrite,
	input  wire logic [7:0] trimWrData,
	input  wire logic [7:0] factoryTrim,
	output logic            battery_low_flag,
	output logic            century_count_b0,
	output logic            century_count_b1,
	output logic            leapYear,
	output logic            osc_fail_flag,
	output logic            shared_irq_pin_o,
	output logic            shared_irq_pin_oe,
	output logic            oscillator_halt_ctrl,
	output logic            freq_test_bit,
	output logic            oscfail_irq_enable,
	output logic            alarm1_irq_enable,
	output logic            square_wave_on,
	output logic            alarm_in_backup_en,
	output logic            power_loss_stamp,
	output logic            countdown_run_bit,
	output logic [1:0]      countdown_clock_sel,
	output logic            sqw_rate_sel0,
	output logic [2:0]      sqw_rate_sel_upper,
	output logic            alarm2_enable,
	output logic            outLevel,
	output logic            trimLoadBit,
	output logic [7:0]      trimValue,
	output logic            trimLoaded
);
	logic              mainsPrev_q;
	logic              batLow_q;
	logic              batLow_d;
	logic [31:0]       checkCnt_q;
	logic [31:0]       checkCnt_d;
	logic [1:0]        century_q;
	logic              oscFail_q;
	logic              oscFail_d;
	logic              irqLow_q;
	logic              irqLow_d;
	logic              halt_q;
	logic              ftest_q;
	logic              oscfail_irq_enable_q;
	logic              alarm1_irq_enable_q;
	logic              square_wave_on_q;
	logic              abe_q;
	logic              stamp_q;
	logic              run_q;
	logic [1:0]        clkSel_q;
	logic              rate0_q;
	logic [2:0]        rateUp_q;
	logic              alarm2_enable_q;
	logic              out_q;
	logic              tload_q;
	logic              leap_q;
	logic [7:0]        trimVal;
	logic              trimDone;
	rsd_pkg::rsd_pwr_e pwr;
	logic              doCheck;
	logic              intervalDone;
	logic              anyIrqSource;

	// ==========================================
	// power phase: rising mains edge splits first from later power-up
	assign pwr = !mainsGood ? rsd_pkg::RSD_PWR_OFF :
		mainsPrev_q ? rsd_pkg::RSD_PWR_ON :
		firstPowerUp ? rsd_pkg::RSD_PWR_FIRST : rsd_pkg::RSD_PWR_LATER;

	// ==========================================
	// battery check on power-up and on interval expiry
	assign intervalDone = oscTick && checkCnt_q >= CHECK_TICKS - 32'h1;
	assign doCheck      = mainsGood && (pwr != rsd_pkg::RSD_PWR_ON || intervalDone);
	assign checkCnt_d   = (!mainsGood || doCheck) ? 32'h0 :
		oscTick ? checkCnt_q + 32'h1 : checkCnt_q;
	assign batLow_d     = doCheck ? !batteryOk : batLow_q;

	// ==========================================
	// oscillator fail: hardware set beats software clear
	always_comb begin
		case (pwr)
			rsd_pkg::RSD_PWR_FIRST: oscFail_d = `RSD_INIT_OSCFAIL;
			default: begin
				if (!oscRunning || halt_q)
					oscFail_d = 1'b1;
				else if (oscFailClear)
					oscFail_d = 1'b0;
				else
					oscFail_d = oscFail_q;
			end
		endcase
	end

	// ==========================================
	// shared open-drain pin: low when an enabled source asks, or output bit is zero with no source enabled
	assign anyIrqSource = oscfail_irq_enable_q || alarm1_irq_enable_q || watchdogIrqOn;
	assign irqLow_d = (oscfail_irq_enable_q && oscFail_q) || (alarm1_irq_enable_q && alarm1Irq) ||
		(watchdogIrqOn && watchdogIrq) || (!anyIrqSource && !out_q);

	// ==========================================
	// status and pin registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mainsPrev_q <= 1'b0;
			batLow_q    <= 1'b0;
			checkCnt_q  <= 32'h0;
			oscFail_q   <= 1'b1;
			irqLow_q    <= 1'b0;
			leap_q      <= 1'b0;
		end else begin
			mainsPrev_q <= mainsGood;
			batLow_q    <= batLow_d;
			checkCnt_q  <= checkCnt_d;
			oscFail_q   <= oscFail_d;
			irqLow_q    <= irqLow_d;
			leap_q      <= (yearUnits[1:0] == 2'h0) &&
				(yearUnits != 8'h00 || century_q == 2'h0);
		end
	end

	// ==========================================
	// control bits with power-up defaults and software writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			century_q <= 2'h0;
			halt_q    <= 1'b0;
			ftest_q   <= 1'b0;
			oscfail_irq_enable_q    <= 1'b0;
			alarm1_irq_enable_q    <= 1'b0;
			square_wave_on_q    <= `RSD_INIT_SQUARE_WAVE_ON;
			abe_q     <= 1'b0;
			stamp_q   <= `RSD_INIT_STAMP;
			run_q     <= 1'b0;
			clkSel_q  <= `RSD_INIT_CLKSEL;
			rate0_q   <= `RSD_INIT_RATE0;
			rateUp_q  <= 3'h0;
			alarm2_enable_q    <= 1'b0;
			out_q     <= `RSD_INIT_OUT;
			tload_q   <= 1'b0;
		end else if (pwr == rsd_pkg::RSD_PWR_FIRST) begin
			century_q <= 2'h0;
			halt_q    <= 1'b0;
			ftest_q   <= 1'b0;
			oscfail_irq_enable_q    <= 1'b0;
			alarm1_irq_enable_q    <= 1'b0;
			square_wave_on_q    <= `RSD_INIT_SQUARE_WAVE_ON;
			abe_q     <= 1'b0;
			out_q     <= `RSD_INIT_OUT;
			stamp_q   <= `RSD_INIT_STAMP;
			run_q     <= 1'b0;
			clkSel_q  <= `RSD_INIT_CLKSEL;
			rate0_q   <= `RSD_INIT_RATE0;
			rateUp_q  <= 3'h0;
			alarm2_enable_q    <= 1'b0;
			tload_q   <= 1'b0;
		end else if (pwr == rsd_pkg::RSD_PWR_LATER) begin
			ftest_q   <= 1'b0;
			run_q     <= 1'b0;
			stamp_q   <= 1'b1;
		end else begin
			if (yearRollover)
				century_q <= century_q + 2'h1;
			if (ctrlWrite) begin
				out_q    <= ctrlWrData[`RSD_CTRL_OUT_BIT];
				halt_q   <= ctrlWrData[6];
				ftest_q  <= ctrlWrData[5];
				oscfail_irq_enable_q   <= ctrlWrData[4];
				alarm1_irq_enable_q   <= ctrlWrData[3];
				square_wave_on_q   <= ctrlWrData[2];
				tload_q  <= ctrlWrData[1];
				run_q    <= ctrlWrData[0];
			end
		end
	end

	// ==========================================
	// analog trim storage
	rsd_trim_loader u_trim (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.oscTick     (oscTick),
		.trimLoadBit (tload_q),
		.trimWrite   (trimWrite),
		.trimWrData  (trimWrData),
		.factoryTrim (factoryTrim),
		.trimValue   (trimVal),
		.trimLoaded  (trimDone)
	);

	// ==========================================
	// outputs straight from flops, except interrupt pin data tied low
	assign battery_low_flag     = batLow_q;
	assign century_count_b0     = century_q[0];
	assign century_count_b1     = century_q[1];
	assign leapYear             = leap_q;
	assign osc_fail_flag        = oscFail_q;
	assign shared_irq_pin_o     = 1'b0;
	assign shared_irq_pin_oe    = irqLow_q;
	assign oscillator_halt_ctrl = halt_q;
	assign freq_test_bit        = ftest_q;
	assign oscfail_irq_enable   = oscfail_irq_enable_q;
	assign alarm1_irq_enable    = alarm1_irq_enable_q;
	assign square_wave_on       = square_wave_on_q;
	assign alarm_in_backup_en   = abe_q;
	assign power_loss_stamp     = stamp_q;
	assign countdown_run_bit    = run_q;
	assign countdown_clock_sel  = clkSel_q;
	assign sqw_rate_sel0        = rate0_q;
	assign sqw_rate_sel_upper   = rateUp_q;
	assign alarm2_enable        = alarm2_enable_q;
	assign outLevel             = out_q;
	assign trimLoadBit          = tload_q;
	assign trimValue            = trimVal;
	assign trimLoaded           = trimDone;
endmodule

// File: rtl/rsd_trim_loader.sv
// analog trim register with factory-value load
`timescale 1ns/1ps
`include "rsd_defs.svh"
module rsd_trim_loader (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       oscTick,
	input  wire logic       trimLoadBit,
	input  wire logic       trimWrite,
	input  wire logic [7:0] trimWrData,
	input  wire logic [7:0] factoryTrim,
	output logic      [7:0] trimValue,
	output logic            trimLoaded
);
	logic [7:0]  trim_q;
	logic [7:0]  trim_d;
	logic [11:0] wait_q;
	logic [11:0] wait_d;
	logic        done_q;

	// ==========================================
	// load delay and register storage
	assign wait_d = !trimLoadBit ? 12'h000 :
		(oscTick && wait_q != 12'(`RSD_TRIM_LOAD_TICKS)) ? wait_q + 12'h001 : wait_q;
	assign trim_d = (trimLoadBit && wait_q == 12'(`RSD_TRIM_LOAD_TICKS)) ? factoryTrim :
		(!trimLoadBit && trimWrite) ? trimWrData : trim_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trim_q <= 8'h00;
			wait_q <= 12'h000;
			done_q <= 1'b0;
		end else begin
			trim_q <= trim_d;
			wait_q <= wait_d;
			done_q <= trimLoadBit && wait_q == 12'(`RSD_TRIM_LOAD_TICKS);
		end
	end

	assign trimValue  = trim_q;
	assign trimLoaded = done_q;
endmodule

// File: tb/rsd_supervisor_asserts.sv
// assertion checker of the rtc supervision block
`timescale 1ns/1ps
module rsd_supervisor_asserts (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       mainsGood,
	input wire logic       firstPowerUp,
	input wire logic       batteryOk,
	input wire logic       oscRunning,
	input wire logic       yearRollover,
	input wire logic [7:0] yearUnits,
	input wire logic       oscFailClear,
	input wire logic       watchdogIrqOn,
	input wire logic       battery_low_flag,
	input wire logic       century_count_b0,
	input wire logic       century_count_b1,
	input wire logic       leapYear,
	input wire logic       osc_fail_flag,
	input wire logic       shared_irq_pin_o,
	input wire logic       shared_irq_pin_oe,
	input wire logic       freq_test_bit,
	input wire logic       oscfail_irq_enable,
	input wire logic       alarm1_irq_enable,
	input wire logic       power_loss_stamp,
	input wire logic       countdown_run_bit,
	input wire logic       outLevel
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================
	// helpers
	wire logic [1:0] cent  = {century_count_b1, century_count_b0};
	wire logic       quiet = !oscfail_irq_enable && !alarm1_irq_enable && !watchdogIrqOn;
	sequence sPowerUp;
		$rose(mainsGood);
	endsequence
	sequence sQuiet;
		(quiet && $stable(outLevel))[*2];
	endsequence
	// ==========================================
	// properties
	AST_PIN_OD: assert property (shared_irq_pin_o == 1'b0)
		else $error("interrupt pin driven high");
	AST_PIN_OUT: assert property (sQuiet |-> shared_irq_pin_oe == !outLevel)
		else $error("pin does not follow output level");
	AST_PIN_FAIL: assert property (osc_fail_flag && oscfail_irq_enable |=> shared_irq_pin_oe)
		else $error("oscillator fail interrupt missing");
	AST_OSC_SET: assert property (!oscRunning |=> osc_fail_flag)
		else $error("oscillator fail flag not set");
	AST_OSC_HOLD: assert property (osc_fail_flag && !oscFailClear |=> osc_fail_flag)
		else $error("oscillator fail flag dropped");
	AST_CENTURY: assert property (yearRollover && mainsGood && $stable(mainsGood) |=> cent == $past(cent) + 2'h1)
		else $error("century count wrong");
	AST_LEAP: assert property (($stable(yearUnits) && $stable(cent))[*2] |->
		leapYear == (yearUnits[1:0] == 2'h0 && (yearUnits != 8'h00 || cent == 2'h0)))
		else $error("leap year wrong");
	AST_BAT_PWR: assert property (sPowerUp |=> battery_low_flag == !$past(batteryOk))
		else $error("battery check at power-up wrong");
	AST_BAT_BACKUP: assert property (!mainsGood |=> $stable(battery_low_flag))
		else $error("battery check during backup");
	AST_FIRST_DEF: assert property (sPowerUp ##0 firstPowerUp |=> power_loss_stamp && osc_fail_flag && outLevel
		&& cent == 2'h0 && !freq_test_bit && !oscfail_irq_enable && !countdown_run_bit)
		else $error("first power-up defaults wrong");
	AST_LATER_DEF: assert property (sPowerUp ##0 !firstPowerUp |=> power_loss_stamp && !freq_test_bit
		&& !countdown_run_bit && $stable(cent))
		else $error("later power-up defaults wrong");
endmodule

bind rsd_supervisor rsd_supervisor_asserts i_asserts (
	.ref_clk, .rst_n, .mainsGood, .firstPowerUp, .batteryOk, .oscRunning, .yearRollover, .yearUnits,
	.oscFailClear, .watchdogIrqOn, .battery_low_flag, .century_count_b0, .century_count_b1, .leapYear,
	.osc_fail_flag, .shared_irq_pin_o, .shared_irq_pin_oe, .freq_test_bit, .oscfail_irq_enable,
	.alarm1_irq_enable, .power_loss_stamp, .countdown_run_bit, .outLevel
);

// File: tb/rsd_supervisor_tb_top.sv
// testbench of the rtc supervision block
`timescale 1ns/1ps
`include "rsd_defs.svh"
module rsd_supervisor_tb_top;
	logic       ref_clk = 1'b0, rst_n = 1'b0, oscTick = 1'b0, mainsGood = 1'b0, firstPowerUp = 1'b1;
	logic       batteryOk = 1'b0, oscRunning = 1'b1, yearRollover = 1'b0, ctrlWrite = 1'b0, oscFailClear = 1'b0;
	logic       watchdogIrqOn = 1'b0, alarm1Irq = 1'b0, watchdogIrq = 1'b0, trimWrite = 1'b0;
	logic [7:0] yearUnits = 8'h00, ctrlWrData = 8'h00, trimWrData = 8'h00, factoryTrim = 8'h5A;
	logic       battery_low_flag, century_count_b0, century_count_b1, leapYear, osc_fail_flag, shared_irq_pin_o;
	logic       shared_irq_pin_oe, oscillator_halt_ctrl, freq_test_bit, oscfail_irq_enable, alarm1_irq_enable;
	logic       square_wave_on, alarm_in_backup_en, power_loss_stamp, countdown_run_bit, sqw_rate_sel0;
	logic       alarm2_enable, outLevel, trimLoadBit, trimLoaded;
	logic [1:0] countdown_clock_sel;
	logic [2:0] sqw_rate_sel_upper;
	logic [7:0] trimValue;
	int         compares = 0, miscompares = 0;
	// ==========================================
	// design with a short battery check interval
	rsd_supervisor #(.CHECK_TICKS(32'h10)) i_dut (
		.ref_clk, .rst_n, .oscTick, .mainsGood, .firstPowerUp, .batteryOk, .oscRunning, .yearRollover, .yearUnits,
		.ctrlWrite, .ctrlWrData, .oscFailClear, .watchdogIrqOn, .alarm1Irq, .watchdogIrq, .trimWrite, .trimWrData,
		.factoryTrim, .battery_low_flag, .century_count_b0, .century_count_b1, .leapYear, .osc_fail_flag,
		.shared_irq_pin_o, .shared_irq_pin_oe, .oscillator_halt_ctrl, .freq_test_bit, .oscfail_irq_enable,
		.alarm1_irq_enable, .square_wave_on, .alarm_in_backup_en, .power_loss_stamp, .countdown_run_bit,
		.countdown_clock_sel, .sqw_rate_sel0, .sqw_rate_sel_upper, .alarm2_enable, .outLevel, .trimLoadBit,
		.trimValue, .trimLoaded
	);
	always #5 ref_clk = ~ref_clk;
	// ==========================================
	// shared tasks, all driving at the falling edge
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] d);
		@(negedge ref_clk) ctrlWrData = d;
		ctrlWrite = 1'b1;
		@(negedge ref_clk) ctrlWrite = 1'b0;
	endtask
	task automatic tw(input logic [7:0] d);
		@(negedge ref_clk) trimWrData = d;
		trimWrite = 1'b1;
		@(negedge ref_clk) trimWrite = 1'b0;
		cyc(1);
	endtask
	task automatic clr();
		@(negedge ref_clk) oscFailClear = 1'b1;
		@(negedge ref_clk) oscFailClear = 1'b0;
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(negedge ref_clk) oscTick = 1'b1;
			@(negedge ref_clk) oscTick = 1'b0;
		end
	endtask
	task automatic power(input logic first);
		@(negedge ref_clk) mainsGood = 1'b0;
		cyc(3);
		firstPowerUp = first;
		mainsGood = 1'b1;
		cyc(2);
	endtask
	// ==========================================
	// scenarios
	task automatic t_first();
		power(1'b1);
		chk("ones", 8'hFF, {power_loss_stamp, osc_fail_flag, outLevel, square_wave_on, countdown_clock_sel,
			sqw_rate_sel0, battery_low_flag});
		chk("zeros", 8'h00, {oscillator_halt_ctrl, freq_test_bit, oscfail_irq_enable, alarm1_irq_enable,
			alarm_in_backup_en, countdown_run_bit, alarm2_enable, trimLoadBit});
		chk("upper", 8'h00, {3'h0, sqw_rate_sel_upper, century_count_b1, century_count_b0});
		$display("test first power-up done");
	endtask
	task automatic t_battery();
		batteryOk = 1'b1;
		tick(8);
		chk("batLow", 8'h01, {7'h00, battery_low_flag});
		tick(10);
		cyc(2);
		chk("batLow", 8'h00, {7'h00, battery_low_flag});
		wr(8'hA5);
		mainsGood = 1'b0;
		batteryOk = 1'b0;
		tick(40);
		chk("batLow", 8'h00, {7'h00, battery_low_flag});
		power(1'b0);
		chk("batLow", 8'h01, {7'h00, battery_low_flag});
		chk("later", 8'h1C, {3'h0, square_wave_on, power_loss_stamp, outLevel, freq_test_bit,
			countdown_run_bit});
		$display("test battery done");
	endtask
	task automatic t_pin();
		clr();
		chk("oscFail", 8'h00, {7'h00, osc_fail_flag});
		wr(8'h04);
		cyc(1);
		chk("pinOe", 8'h01, {7'h00, shared_irq_pin_oe});
		chk("pinOut", 8'h00, {7'h00, shared_irq_pin_o});
		wr(8'h94);
		cyc(1);
		chk("pinOe", 8'h00, {7'h00, shared_irq_pin_oe});
		oscRunning = 1'b0;
		cyc(1);
		oscRunning = 1'b1;
		cyc(2);
		chk("pinOe", 8'h01, {7'h00, shared_irq_pin_oe});
		clr();
		cyc(1);
		chk("pinOe", 8'h00, {7'h00, shared_irq_pin_oe});
		wr(8'hC4);
		clr();
		chk("oscFail", 8'h01, {7'h00, osc_fail_flag});
		wr(8'h84);
		cyc(1);
		chk("pinOe", 8'h00, {7'h00, shared_irq_pin_oe});
		clr();
		chk("oscFail", 8'h00, {7'h00, osc_fail_flag});
		wr(8'h0C);
		cyc(1);
		chk("pinOe", 8'h00, {7'h00, shared_irq_pin_oe});
		alarm1Irq = 1'b1;
		cyc(2);
		chk("pinOe", 8'h01, {7'h00, shared_irq_pin_oe});
		alarm1Irq = 1'b0;
		wr(8'h04);
		watchdogIrqOn = 1'b1;
		cyc(2);
		chk("pinOe", 8'h00, {7'h00, shared_irq_pin_oe});
		watchdogIrq = 1'b1;
		cyc(2);
		chk("pinOe", 8'h01, {7'h00, shared_irq_pin_oe});
		watchdogIrqOn = 1'b0;
		watchdogIrq = 1'b0;
		wr(8'h84);
		cyc(1);
		chk("pinOe", 8'h00, {7'h00, shared_irq_pin_oe});
		$display("test interrupt pin done");
	endtask
	task automatic t_century();
		for (int i = 0; i < 4; i++) begin
			yearUnits = 8'h00;
			cyc(2);
			chk("leap00", {7'h00, i == 0}, {7'h00, leapYear});
			yearUnits = 8'h62;
			cyc(2);
			chk("leap98", 8'h00, {7'h00, leapYear});
			yearRollover = 1'b1;
			cyc(1);
			yearRollover = 1'b0;
			cyc(1);
			chk("century", 8'((i + 1) % 4), {6'h00, century_count_b1, century_count_b0});
		end
		yearUnits = 8'h04;
		cyc(2);
		chk("leap04", 8'h01, {7'h00, leapYear});
		$display("test century done");
	endtask
	task automatic t_trim();
		tw(8'hC3);
		chk("trim", 8'hC3, trimValue);
		wr(8'h86);
		tick(`RSD_TRIM_LOAD_TICKS + 2);
		cyc(2);
		chk("trimDone", 8'h01, {7'h00, trimLoaded});
		tw(8'h33);
		chk("trim", 8'h5A, trimValue);
		$display("test trim done");
	endtask
	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ==========================================
	// main sequence and watchdog, about thirteen times the expected run
	initial begin
		repeat (4) @(negedge ref_clk);
		rst_n = 1'b1;
		cyc(2);
		t_first();
		t_battery();
		t_pin();
		t_century();
		t_trim();
		end_of_test();
	end
	initial begin
		#100000;
		miscompares++;
		end_of_test();
	end
endmodule
